// ---- core/mir_pkg.sv ----
package mir_pkg;
    // ==========================================================
    // Register offsets
    localparam logic [7:0] ADDR_MODE = 8'h06;
    localparam logic [7:0] ADDR_SUMMARY = 8'h07;
    localparam logic [7:0] ADDR_BUS_SRC = 8'h08;
    localparam logic [7:0] ADDR_WAKE_SRC = 8'h09;
    localparam logic [7:0] ADDR_SUPPLY_SRC = 8'h0A;
    // ==========================================================
    // Reset values and writable-bit masks
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic DCDC_RESET = 1'h1;
    localparam logic IRQ_N_RESET = 1'h1;
    localparam logic [7:0] BUS_SRC_MASK = 8'hDF;
    localparam logic [7:0] WAKE_SRC_MASK = 8'h0F;
    localparam logic [7:0] SUPPLY_SRC_MASK = 8'hFF;
    // ==========================================================
    // Field positions
    localparam int MODE_REQ_LSB = 0;
    localparam int MODE_STATE_LSB = 4;
    localparam int SUM_BUS_BIT = 0;
    localparam int SUM_WAKE_BIT = 1;
    localparam int SUM_SUPPLY_BIT = 2;
    // ==========================================================
    // Mode encodings
    localparam logic [1:0] MODE_STANDBY = 2'h0;
    localparam logic [1:0] MODE_NORMAL = 2'h1;
    localparam logic [1:0] MODE_RXONLY = 2'h2;
    localparam logic [1:0] MODE_SLEEP = 2'h3;

    // Register port request
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } mir_req_s;

    // Bus fault event strobes, bit order as in the source register
    typedef struct packed {
        logic bus_dominant;
        logic txd_rxd_short;
        logic txd_dominant;
        logic canl_vcc;
        logic canl_gnd;
        logic canh_gnd;
        logic canh_vcc;
    } mir_bus_ev_s;
endpackage : mir_pkg

// ---- core/mir_src_reg.sv ----
`timescale 1ns/1ps
`default_nettype none
// Sticky event register: set wins over host clear
module mir_src_reg #(
    parameter logic [7:0] MASK = 8'hFF
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic [7:0] event_in,
    input wire logic wr_en,
    input wire logic [7:0] wdata,
    output logic [7:0] value,
    output logic pending
);
    // ==========================================================
    // Storage
    logic [7:0] val_r;
    logic [7:0] val_nxt;

    // Write-zero clears, events set, reserved stay zero
    always_comb begin
        val_nxt = val_r;
        if (wr_en) begin
            val_nxt = val_r & wdata;
        end
        val_nxt = (val_nxt | event_in) & MASK;
    end

    // State update
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            val_r <= mir_pkg::REG_RESET;
        end else begin
            val_r <= val_nxt;
        end
    end

    assign value = val_r;
    assign pending = |val_r;

    // Event always lands even against a clearing write
    a_set_wins: assert property (
        @(posedge clock) disable iff (!resetn)
        (event_in & MASK) != 8'h00
        |=> (val_r & ($past(event_in) & MASK)) == ($past(event_in) & MASK))
        else $error("event lost");
    // Reserved bits never set
    a_reserved_zero: assert property (
        @(posedge clock) disable iff (!resetn)
        (val_r & ~MASK) == 8'h00)
        else $error("reserved bit set");
endmodule : mir_src_reg
`default_nettype wire

// ---- core/mir_top.sv ----
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Two-bit mode request plus read-only state echo
// - Sleep-supply bit keeps 5V converter in sleep
// - Summary bit 2: supply interrupt pending
// - Summary bit 1: wake or temperature pending
// - Summary bit 0: bus or pin failure
// - Source1 bit 7: bus held dominant
// - Source1 bit 6: TX/RX short; bit 5 reserved
// - Source1 bit 4: transmit input stuck dominant
// - Source1 bits 3..0: CANL/CANH line shorts
// - Source2 bit 3: temperature recovered; 7..4 reserved
// - Source2 bit 2: temperature above warning
// - Source2 bit 1: local wake pin event
// - Source2 bit 0: remote bus wake
// - Source3: good/undervoltage pairs per rail
module mir_top (
    input wire logic clock,
    input wire logic resetn,
    input wire mir_pkg::mir_req_s req,
    output logic [7:0] rdata,
    input wire logic sleep_supply_cfg,
    input wire logic [1:0] device_state,
    input wire mir_pkg::mir_bus_ev_s bus_ev,
    input wire logic temp_recover_ev,
    input wire logic temp_warning_threshold,
    input wire logic local_wake_ev,
    input wire logic remote_wake_ev,
    input wire logic [7:0] supply_ev,
    output logic [1:0] mode_req,
    output logic dcdc_enable,
    output logic interrupt_out_n
);
    // ==========================================================
    // Mode request register
    logic [1:0] mode_r;
    logic [7:0] bus_val;
    logic [7:0] wake_val;
    logic [7:0] sup_val;
    logic bus_pend;
    logic wake_pend;
    logic sup_pend;
    logic [7:0] bus_evt;
    logic [7:0] wake_evt;
    logic [2:0] summary;
    logic [7:0] rdata_nxt;

    // Strobe decode shared by the register writes and the checks
    function automatic logic wr_hit(input logic [7:0] a);
        return req.wr && (req.addr == a);
    endfunction : wr_hit
    function automatic logic rd_hit(input logic [7:0] a);
        return req.rd && (req.addr == a);
    endfunction : rd_hit

    // Host writes the request field only
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            mode_r <= mir_pkg::MODE_STANDBY;
        end else if (wr_hit(mir_pkg::ADDR_MODE)) begin
            mode_r <= req.wdata[mir_pkg::MODE_REQ_LSB +: 2];
        end
    end
    assign mode_req = mode_r;

    // Converter gating in sleep
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            dcdc_enable <= mir_pkg::DCDC_RESET;
        end else begin
            dcdc_enable <= (mode_r != mir_pkg::MODE_SLEEP)
                || sleep_supply_cfg;
        end
    end

    // ==========================================================
    // Source registers
    assign bus_evt = {bus_ev.bus_dominant, bus_ev.txd_rxd_short, 1'h0,
        bus_ev.txd_dominant, bus_ev.canl_vcc, bus_ev.canl_gnd,
        bus_ev.canh_gnd, bus_ev.canh_vcc};
    assign wake_evt = {4'h0, temp_recover_ev, temp_warning_threshold,
        local_wake_ev, remote_wake_ev};

    mir_src_reg #(.MASK(mir_pkg::BUS_SRC_MASK)) u_bus (
        .clock(clock),
        .resetn(resetn),
        .event_in(bus_evt),
        .wr_en(wr_hit(mir_pkg::ADDR_BUS_SRC)),
        .wdata(req.wdata),
        .value(bus_val),
        .pending(bus_pend)
    );
    mir_src_reg #(.MASK(mir_pkg::WAKE_SRC_MASK)) u_wake (
        .clock(clock),
        .resetn(resetn),
        .event_in(wake_evt),
        .wr_en(wr_hit(mir_pkg::ADDR_WAKE_SRC)),
        .wdata(req.wdata),
        .value(wake_val),
        .pending(wake_pend)
    );
    mir_src_reg #(.MASK(mir_pkg::SUPPLY_SRC_MASK)) u_sup (
        .clock(clock),
        .resetn(resetn),
        .event_in(supply_ev),
        .wr_en(wr_hit(mir_pkg::ADDR_SUPPLY_SRC)),
        .wdata(req.wdata),
        .value(sup_val),
        .pending(sup_pend)
    );

    // ==========================================================
    // Summary and interrupt pin
    always_comb begin
        summary = 3'h0;
        summary[mir_pkg::SUM_SUPPLY_BIT] = sup_pend;
        summary[mir_pkg::SUM_WAKE_BIT] = wake_pend;
        summary[mir_pkg::SUM_BUS_BIT] = bus_pend;
    end

    // Registered active-low interrupt
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            interrupt_out_n <= mir_pkg::IRQ_N_RESET;
        end else begin
            interrupt_out_n <= ~(|summary);
        end
    end

    // ==========================================================
    // Read data
    always_comb begin
        rdata_nxt = 8'h00;
        case (req.addr)
            mir_pkg::ADDR_MODE: begin
                rdata_nxt[mir_pkg::MODE_REQ_LSB +: 2] = mode_r;
                rdata_nxt[mir_pkg::MODE_STATE_LSB +: 2] = device_state;
            end
            mir_pkg::ADDR_SUMMARY: rdata_nxt = {5'h00, summary};
            mir_pkg::ADDR_BUS_SRC: rdata_nxt = bus_val;
            mir_pkg::ADDR_WAKE_SRC: rdata_nxt = wake_val;
            mir_pkg::ADDR_SUPPLY_SRC: rdata_nxt = sup_val;
            default: rdata_nxt = 8'h00;
        endcase
    end

    // Read data registered one cycle after the read
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            rdata <= mir_pkg::REG_RESET;
        end else if (req.rd) begin
            rdata <= rdata_nxt;
        end
    end

    // ==========================================================
    // Checks
    a_int_pin_follows: assert property (
        @(posedge clock) disable iff (!resetn)
        ##1 interrupt_out_n == ($past(summary) == 3'h0))
        else $error("interrupt pin wrong");
    a_sleep_dcdc_off: assert property (
        @(posedge clock) disable iff (!resetn)
        (mode_r == mir_pkg::MODE_SLEEP && !sleep_supply_cfg) |=> !dcdc_enable)
        else $error("converter on in sleep");
    a_sleep_dcdc_keep: assert property (
        @(posedge clock) disable iff (!resetn)
        sleep_supply_cfg |=> dcdc_enable)
        else $error("converter off with keep bit");
    a_mode_write: assert property (
        @(posedge clock) disable iff (!resetn)
        wr_hit(mir_pkg::ADDR_MODE) |=>
        mode_r == $past(req.wdata[mir_pkg::MODE_REQ_LSB +: 2]))
        else $error("mode write lost");
    a_mode_hold: assert property (
        @(posedge clock) disable iff (!resetn)
        !wr_hit(mir_pkg::ADDR_MODE) |=> $stable(mode_r))
        else $error("mode moved without write");
    a_sum_supply: assert property (
        @(posedge clock) disable iff (!resetn)
        supply_ev != 8'h00 |=> summary[mir_pkg::SUM_SUPPLY_BIT])
        else $error("supply summary wrong");
    a_sum_wake: assert property (
        @(posedge clock) disable iff (!resetn)
        $rose(remote_wake_ev) |=> summary[mir_pkg::SUM_WAKE_BIT])
        else $error("wake summary wrong");
    a_sum_bus: assert property (
        @(posedge clock) disable iff (!resetn)
        bus_ev.bus_dominant |=> bus_val[7] && summary[mir_pkg::SUM_BUS_BIT])
        else $error("bus summary wrong");
    a_bus_short: assert property (
        @(posedge clock) disable iff (!resetn)
        bus_ev.canh_vcc |=> bus_val[0])
        else $error("line short lost");
    a_temp_warn: assert property (
        @(posedge clock) disable iff (!resetn)
        temp_warning_threshold |=> wake_val[2])
        else $error("temperature warning lost");
    a_temp_recover: assert property (
        @(posedge clock) disable iff (!resetn)
        temp_recover_ev |=> wake_val[3])
        else $error("temperature recovery lost");
    a_local_wake: assert property (
        @(posedge clock) disable iff (!resetn)
        local_wake_ev |=> wake_val[1])
        else $error("local wake lost");
    a_dcdc_awake: assert property (
        @(posedge clock) disable iff (!resetn)
        mode_r != mir_pkg::MODE_SLEEP |=> dcdc_enable)
        else $error("converter off while awake");
    a_read_summary: assert property (
        @(posedge clock) disable iff (!resetn)
        rd_hit(mir_pkg::ADDR_SUMMARY) |=> rdata == {5'h00, $past(summary)})
        else $error("summary read wrong");
    a_read_mode: assert property (
        @(posedge clock) disable iff (!resetn)
        rd_hit(mir_pkg::ADDR_MODE) |=>
        rdata == {2'h0, $past(device_state), 2'h0, $past(mode_r)})
        else $error("mode read wrong");
    a_read_unmapped: assert property (
        @(posedge clock) disable iff (!resetn)
        req.rd && (req.addr < mir_pkg::ADDR_MODE
        || req.addr > mir_pkg::ADDR_SUPPLY_SRC) |=> rdata == 8'h00)
        else $error("unmapped read not zero");
endmodule : mir_top
`default_nettype wire

// ---- dv/mir_host.sv ----
`timescale 1ns/1ps
`default_nettype none
// Host model: one-byte register cycles launched at falling edge
module mir_host (
    input wire logic clock,
    input wire logic [7:0] rdata,
    output var mir_pkg::mir_req_s req
);
    // Idle request at time zero
    initial begin
        req = '0;
    end

    // Write strobe for one cycle, then released lines show inverse
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clock);
        req = '{1'h1, 1'h0, a, d};
        @(negedge clock);
        req = '{1'h0, 1'h0, ~a, ~d};
    endtask : wr

    // Read strobe for one cycle, data taken a cycle later
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clock);
        req = '{1'h0, 1'h1, a, 8'h00};
        @(negedge clock);
        req = '{1'h0, 1'h0, ~a, 8'hFF};
        d = rdata;
    endtask : rd
endmodule : mir_host
`default_nettype wire

// ---- dv/tb_mode_and_interrupt_regs.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_mode_and_interrupt_regs;
    typedef struct packed {
        logic [6:0] b;
        logic [3:0] w;
        logic [7:0] s;
        logic [7:0] eb;
        logic [7:0] ew;
    } mir_row_s;
    // ==========================================================
    // Signals
    logic clock, resetn, cfg, dcdc_enable, interrupt_out_n;
    logic [1:0] dst, mode_req;
    logic [3:0] w;
    logic [7:0] sup, rdata, d;
    mir_pkg::mir_req_s req;
    mir_pkg::mir_bus_ev_s bus;
    int err_total = 0;
    int checked = 0;
    mir_row_s rows [9] = '{'{7'h40, 4'h0, 8'h00, 8'h80, 8'h00},
        '{7'h20, 4'h0, 8'h00, 8'h40, 8'h00},
        '{7'h10, 4'h0, 8'h00, 8'h10, 8'h00},
        '{7'h0F, 4'h0, 8'h00, 8'h0F, 8'h00},
        '{7'h00, 4'h8, 8'h00, 8'h00, 8'h08},
        '{7'h00, 4'h4, 8'h00, 8'h00, 8'h04},
        '{7'h00, 4'h2, 8'h00, 8'h00, 8'h02},
        '{7'h00, 4'h1, 8'h00, 8'h00, 8'h01},
        '{7'h00, 4'h0, 8'hA5, 8'h00, 8'h00}};
    // ==========================================================
    // Design and host
    mir_top i_dut (.clock(clock), .resetn(resetn), .req(req),
        .rdata(rdata), .sleep_supply_cfg(cfg), .device_state(dst),
        .bus_ev(bus), .temp_recover_ev(w[3]),
        .temp_warning_threshold(w[2]), .local_wake_ev(w[1]),
        .remote_wake_ev(w[0]), .supply_ev(sup), .mode_req(mode_req),
        .dcdc_enable(dcdc_enable), .interrupt_out_n(interrupt_out_n));
    mir_host i_host (.clock(clock), .rdata(rdata), .req(req));
    // ==========================================================
    // Checking and verdict
    task automatic chk(string n, logic [7:0] e, logic [7:0] g);
        checked++;
        if (g !== e) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    task automatic close_out;
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : close_out
    // Clock, 10 ns period
    initial begin
        clock = 1'h0;
        forever #5 clock = ~clock;
    end
    // Watchdog
    initial begin
        #200000;
        err_total++;
        close_out();
    end
    // Main sequence
    initial begin
        resetn = 1'h0;
        cfg = 1'h0;
        dst = 2'h0;
        bus = '0;
        w = 4'h0;
        sup = 8'h00;
        repeat (12) @(negedge clock);
        resetn = 1'h1;
        for (int a = 6; a < 11; a++) begin
            i_host.rd(8'(a), d);
            chk("reset reg", 8'h00, d);
        end
        chk("reset out", 8'h03, {6'h00, dcdc_enable, interrupt_out_n});
        $display("test reset done");
        foreach (rows[i]) begin
            @(negedge clock);
            bus = rows[i].b;
            w = rows[i].w;
            sup = rows[i].s;
            @(negedge clock);
            bus = '0;
            w = 4'h0;
            sup = 8'h00;
            i_host.rd(8'h08, d);
            chk("bus src", rows[i].eb, d);
            i_host.rd(8'h09, d);
            chk("wake src", rows[i].ew, d);
            i_host.rd(8'h0A, d);
            chk("supply src", rows[i].s, d);
            i_host.rd(8'h07, d);
            chk("summary",
                {5'h00, |rows[i].s, |rows[i].ew, |rows[i].eb}, d);
            chk("irq set", 8'h00, {7'h00, interrupt_out_n});
            i_host.wr(8'h08, 8'h00);
            i_host.wr(8'h09, 8'h00);
            i_host.wr(8'h0A, 8'h00);
            i_host.rd(8'h07, d);
            chk("cleared", 8'h00, d);
            chk("irq clr", 8'h01, {7'h00, interrupt_out_n});
        end
        $display("test events done");
        for (int i = 0; i < 8; i++) begin
            cfg = i[2];
            dst = (i[1:0] == 2'h3) ? 2'h2 : i[1:0];
            i_host.wr(8'h06, {6'h3F, i[1:0]});
            i_host.rd(8'h06, d);
            chk("mode reg", {2'h0, dst, 2'h0, i[1:0]}, d);
            chk("mode out", {6'h00, i[1:0]}, {6'h00, mode_req});
            chk("dcdc", {7'h00, !(i[1:0] == 2'h3 && !i[2])},
                {7'h00, dcdc_enable});
        end
        $display("test modes done");
        bus = 7'h01;
        i_host.wr(8'h08, 8'h00);
        bus = '0;
        i_host.rd(8'h08, d);
        chk("set wins", 8'h01, d);
        i_host.wr(8'h07, 8'h00);
        i_host.wr(8'h08, 8'hFF);
        i_host.rd(8'h07, d);
        chk("ro summary", 8'h01, d);
        i_host.wr(8'h08, 8'h00);
        i_host.wr(8'h09, 8'hFF);
        i_host.rd(8'h09, d);
        chk("one no set", 8'h00, d);
        i_host.rd(8'h0B, d);
        chk("unmapped", 8'h00, d);
        $display("test awkward done");
        @(negedge clock);
        sup = 8'h01;
        cfg = 1'h0;
        dst = 2'h0;
        @(negedge clock);
        sup = 8'h00;
        resetn = 1'h0;
        repeat (3) @(negedge clock);
        resetn = 1'h1;
        for (int a = 6; a < 11; a++) begin
            i_host.rd(8'(a), d);
            chk("rerun reg", 8'h00, d);
        end
        chk("rerun out", 8'h03, {6'h00, dcdc_enable, interrupt_out_n});
        $display("test midreset done");
        close_out();
    end
endmodule : tb_mode_and_interrupt_regs
`default_nettype wire
